/* File: core/aec_availability.sv */
/*
 * Availability error checking: parity and uncorrectable checks on incoming
 * instruction and data words, unavailable-resource timeout, page-cross,
 * control word parity, outgoing parity generation, syndrome and derail.
 * Assumes the firmware sequencer drives step strobes synchronous to sys_clk_in.
 */
`timescale 1ns/10ps
module aec_availability #(
	parameter int UAR_COUNT = aec_pkg::UAR_CYCLES,
	parameter int UAR_MASTER_COUNT = aec_pkg::UAR_MASTER_CYCLES,
	parameter int DERAIL_COUNT = aec_pkg::DERAIL_CYCLES
) (
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	input wire logic prefetch_strobe_even_in,
	input wire logic prefetch_strobe_odd_in,
	input wire logic [1:0] mem_parity_in,
	input wire logic uncorrectable_indicator_in,
	input wire logic [1:0] take_pair_in,
	input wire logic take_low_in,
	input wire logic [7:0] instr_byte_in,
	input wire logic instr_sample_in,
	input wire logic instr_error_block_in,
	input wire logic error_inhibit_in,
	input wire logic [1:0] inr_load_in,
	input wire logic [1:0] inr_drive_in,
	input wire logic [15:0] result_bus_in,
	input wire logic mid_cycle_in,
	input wire logic step_start_in,
	input wire logic ref_start_in,
	input wire logic ref_read_in,
	input wire logic ref_done_in,
	input wire logic channel_zero_in,
	input wire logic [aec_pkg::ADDR_W-1:0] instr_addr_in,
	input wire logic instr_addr_low_load_in,
	input wire logic instr_remove_in,
	input wire logic long_procedure_mode_in,
	input wire logic [aec_pkg::CW_W-1:0] control_word_in,
	input wire aec_pkg::aec_bus_req_s bus_req_in,
	input wire logic bus_start_in,
	input wire logic command_parity_enable_in,
	input wire logic online_flag_in,
	input wire logic force_error_flag_in,
	input wire logic error_trap_disable_in,
	input wire logic load_syndrome_cmd_in,
	input wire logic test_condition_in,
	output aec_pkg::aec_bus_par_s bus_par_out,
	output logic general_error_collector_out,
	output logic syndrome_clock_out,
	output logic [aec_pkg::SYND_W-1:0] syndrome_bits_out,
	output logic data_parity_error_out,
	output logic unavailable_timeout_out,
	output logic page_cross_flag_out,
	output logic derail_flop_out,
	output logic clock_stall_out,
	output logic next_addr_clear_out,
	output logic else_bank_enable_out
);

	function automatic logic odd_par(input logic [7:0] v);
		odd_par = ~(^v);
	endfunction

	aec_pkg::aec_state_s st;
	aec_pkg::aec_state_s next_st;

	logic [2:0] isel;
	aec_pkg::aec_ibuf_s icur;
	aec_pkg::aec_dbuf_s dcur;
	logic dsel;
	logic ipar_bad;
	logic dpar_err;
	logic dred_err;
	logic [2:0] cw_err;
	logic collect;
	logic force_even;
	logic [15:0] par_src;
	logic [aec_pkg::SYND_W-1:0] sources;
	logic hit;
	logic [7:0] clear_run;
	// Local copy of the timer width so that the compare value can be cut to it.
	localparam int TW = aec_pkg::TIMER_W;

	always_comb begin
		isel = {take_pair_in, take_low_in};
		icur = st.ibuf[isel];
		dsel = inr_drive_in[1];
		dcur = st.dbuf[dsel];
		ipar_bad = instr_sample_in & ((^instr_byte_in) == icur.par[take_low_in]);
		dpar_err = (|inr_drive_in) & ~error_inhibit_in
			& ((^result_bus_in[15:8] == dcur.par[1]) | (^result_bus_in[7:0] == dcur.par[0]));
		dred_err = (|inr_drive_in) & dcur.red & ~error_inhibit_in;
		for (int g = 0; g < aec_pkg::CW_GROUPS; g++) begin
			cw_err[g] = ~(^control_word_in[g*aec_pkg::CW_GROUP_W +: aec_pkg::CW_GROUP_W]);
		end
		sources = '0;
		sources[aec_pkg::SYN_IPAR] = st.ipar_latched & ~instr_error_block_in;
		sources[aec_pkg::SYN_DPAR] = dpar_err;
		sources[aec_pkg::SYN_IRED] = st.ired_latched & ~error_inhibit_in;
		sources[aec_pkg::SYN_DRED] = dred_err;
		sources[aec_pkg::SYN_TMO] = st.unavailable_timeout;
		sources[aec_pkg::SYN_IUAR] = st.iuar_latched;
		sources[aec_pkg::SYN_CS2:aec_pkg::SYN_CS0] = cw_err;
		sources[aec_pkg::SYN_PGX] = st.page_cross_flag;
		collect = (|sources[aec_pkg::SYN_CS2:0]) | load_syndrome_cmd_in;
	end

	always_comb begin
		force_even = ~online_flag_in & force_error_flag_in;
		par_src = bus_req_in.mem_write ? bus_req_in.out_data : bus_req_in.chnl_data;
		bus_par_out = '0;
		if (bus_start_in) begin
			bus_par_out.data_parity[0] = odd_par(par_src[7:0])
				^ (force_even & bus_req_in.mem_write);
			bus_par_out.data_parity[1] = odd_par(par_src[15:8])
				^ (force_even & bus_req_in.mem_write);
			bus_par_out.addr_parity[0] = odd_par(bus_req_in.addr[7:0]);
			bus_par_out.addr_parity[1] = odd_par(bus_req_in.addr[15:8]);
			bus_par_out.addr_parity[2] = odd_par(bus_req_in.addr[23:16]) ^ force_even;
			bus_par_out.cmd_parity = command_parity_enable_in & ~bus_req_in.cmd;
		end
	end

	always_comb begin
		next_st = st;
		hit = 1'b0;
		next_st.strobe_even_d = prefetch_strobe_even_in;
		next_st.strobe_odd_d = prefetch_strobe_odd_in;
		next_st.addr_bit_d = instr_addr_in[aec_pkg::PAGE_BIT];
		// Each strobe edge fills one buffer pair; the pair index follows the documented order.
		for (int p = 0; p < 4; p++) begin
			hit = 1'b0;
			case (p)
				0: hit = prefetch_strobe_odd_in & ~st.strobe_odd_d;
				1: hit = prefetch_strobe_even_in & ~st.strobe_even_d;
				2: hit = ~prefetch_strobe_odd_in & st.strobe_odd_d;
				3: hit = ~prefetch_strobe_even_in & st.strobe_even_d;
				default: hit = 1'b0;
			endcase
			if (hit) begin
				for (int b = 0; b < 2; b++) begin
					next_st.ibuf[p*2+b].par = mem_parity_in;
					next_st.ibuf[p*2+b].red = uncorrectable_indicator_in;
					next_st.ibuf[p*2+b].unavail = st.page_cross_flag;
				end
				next_st.page_cross_flag = 1'b0;
			end
		end
		for (int r = 0; r < 2; r++) begin
			if (inr_load_in[r]) begin
				next_st.dbuf[r].par = mem_parity_in;
				next_st.dbuf[r].red = uncorrectable_indicator_in;
			end
		end
		if (st.addr_bit_d & ~instr_addr_in[aec_pkg::PAGE_BIT] & ~instr_addr_low_load_in) begin
			next_st.page_cross_flag = 1'b1;
		end
		if (mid_cycle_in) begin
			next_st.ipar_latched = ipar_bad;
			next_st.ired_latched = instr_sample_in & icur.red;
			next_st.iuar_latched = instr_remove_in & icur.unavail & ~long_procedure_mode_in;
		end
		// The timer restarts on every reference start; a completion cancels it.
		next_st.unavailable_timeout = 1'b0;
		if (ref_start_in) begin
			next_st.uar_busy = 1'b1;
			next_st.uar_master = channel_zero_in & ref_read_in;
			next_st.uar_timer = '0;
		end else if (ref_done_in) begin
			next_st.uar_busy = 1'b0;
		end else if (st.uar_busy) begin
			next_st.uar_timer = st.uar_timer + 1'b1;
			if (st.uar_timer == TW'(st.uar_master ? UAR_MASTER_COUNT - 1 : UAR_COUNT - 1)) begin
				next_st.unavailable_timeout = 1'b1;
				next_st.uar_busy = 1'b0;
			end
		end
		if (collect) begin
			next_st.collect_d = 1'b1;
		end else if (step_start_in) begin
			next_st.collect_d = 1'b0;
		end
		next_st.syndrome_clock = 1'b0;
		if (st.collect_d & step_start_in) begin
			next_st.syndrome_clock = 1'b1;
			next_st.syndrome_bits = sources;
		end
		// The stall covers the clear phase and one fetch cycle of the zero address.
		case (st.derail)
			aec_pkg::AEC_IDLE: begin
				if (st.syndrome_clock & ~error_trap_disable_in) begin
					next_st.derail_flop = 1'b1;
					next_st.derail = aec_pkg::AEC_STALL;
					next_st.derail_count = '0;
				end
			end
			aec_pkg::AEC_STALL: begin
				next_st.derail_count = st.derail_count + 1'b1;
				if (st.derail_count == 8'(DERAIL_COUNT - 1)) begin
					next_st.derail = aec_pkg::AEC_FETCH;
				end
			end
			aec_pkg::AEC_FETCH: begin
				next_st.derail = aec_pkg::AEC_IDLE;
				next_st.derail_flop = 1'b0;
			end
			default: next_st.derail = aec_pkg::AEC_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign general_error_collector_out = collect;
	assign syndrome_clock_out = st.syndrome_clock;
	assign syndrome_bits_out = st.syndrome_bits;
	assign data_parity_error_out = dpar_err;
	assign unavailable_timeout_out = st.unavailable_timeout;
	assign page_cross_flag_out = st.page_cross_flag;
	assign derail_flop_out = st.derail_flop;
	assign clock_stall_out = st.derail != aec_pkg::AEC_IDLE;
	assign next_addr_clear_out = st.derail == aec_pkg::AEC_STALL;
	assign else_bank_enable_out = ~test_condition_in | (st.derail != aec_pkg::AEC_IDLE);

	// Checker-only count of consecutive cycles with the next-address clear up.
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			clear_run <= 8'h00;
		end else begin
			clear_run <= next_addr_clear_out ? clear_run + 8'h01 : 8'h00;
		end
	end

	a_derail_length: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		$fell(next_addr_clear_out) |-> clear_run == 8'(DERAIL_COUNT))
		else $error("Next-address clear width wrong.");
	a_trap_block: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		syndrome_clock_out && error_trap_disable_in && !derail_flop_out |=> !derail_flop_out)
		else $error("Derail set while trap disabled.");
	a_syndrome_hold: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		!syndrome_clock_out |-> $stable(syndrome_bits_out))
		else $error("Syndrome changed without clock.");
	a_synd_clock: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		$past(collect) && step_start_in |=> syndrome_clock_out)
		else $error("Syndrome clock missing.");
	a_else_bank: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		!test_condition_in |-> else_bank_enable_out)
		else $error("Else bank not enabled.");
	a_cmd_parity: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		!command_parity_enable_in |-> !bus_par_out.cmd_parity)
		else $error("Command parity while disabled.");
	a_odd_addr: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		bus_start_in |-> (^{bus_par_out.addr_parity[0], bus_req_in.addr[7:0]}))
		else $error("Address parity not odd.");
	a_page_cross: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		$fell(instr_addr_in[23]) && !instr_addr_low_load_in |=> page_cross_flag_out)
		else $error("Page-cross flag not armed.");
	a_timeout_gap: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		ref_start_in |=> !unavailable_timeout_out [*8])
		else $error("Timeout too early.");
	// Further checks on the error paths and the outgoing parity.
	a_ld_collect: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		load_syndrome_cmd_in |-> general_error_collector_out)
		else $error("Load-syndrome did not fire the collector.");
	a_cw_collect: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		!(^control_word_in[31:0]) || !(^control_word_in[63:32]) || !(^control_word_in[95:64])
		|-> general_error_collector_out)
		else $error("Control word parity error not collected.");
	a_data_inhibit: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		error_inhibit_in |-> !data_parity_error_out)
		else $error("Data parity error while inhibited.");
	a_tmo_pulse: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		unavailable_timeout_out |=> !unavailable_timeout_out)
		else $error("Timeout longer than one cycle.");
	a_tmo_collect: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		unavailable_timeout_out |-> general_error_collector_out)
		else $error("Timeout not collected.");
	a_derail_start: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		syndrome_clock_out && !error_trap_disable_in && !clock_stall_out |=> derail_flop_out)
		else $error("Derail flop not set.");
	a_derail_stall: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		derail_flop_out |-> clock_stall_out)
		else $error("Derail without clock stall.");
	a_clear_stall: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		next_addr_clear_out |-> clock_stall_out)
		else $error("Next-address clear without clock stall.");
	a_stall_else: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		clock_stall_out |-> else_bank_enable_out)
		else $error("Else bank not forced during derail.");
	a_synd_step: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		syndrome_clock_out |-> $past(step_start_in))
		else $error("Syndrome clock without step start.");
	a_bus_idle: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		!bus_start_in |-> bus_par_out == '0)
		else $error("Parity lines driven outside a transaction.");
	a_odd_data: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		bus_start_in && online_flag_in && bus_req_in.mem_write
		|-> ^{bus_par_out.data_parity[0], bus_req_in.out_data[7:0]})
		else $error("Data parity not odd while on-line.");

endmodule

/* File: include/aec_pkg.sv */
/*
 * Package of the availability error checking block: constants, field positions,
 * timing counts and the packed carriers shared by the design.
 * Assumes a 200 MHz firmware-step clock and synchronous inputs.
 */
package aec_pkg;

	localparam int CLK_PERIOD_PS = 5000;
	localparam int UAR_TIME_NS = 3000;
	localparam int UAR_MASTER_TIME_NS = 5000;
	localparam int DERAIL_TIME_NS = 200;
	localparam int UAR_CYCLES = (UAR_TIME_NS * 1000) / CLK_PERIOD_PS;
	localparam int UAR_MASTER_CYCLES = (UAR_MASTER_TIME_NS * 1000) / CLK_PERIOD_PS;
	localparam int DERAIL_CYCLES = (DERAIL_TIME_NS * 1000) / CLK_PERIOD_PS;
	localparam int TIMER_W = 11;

	localparam int CW_W = 96;
	localparam int CW_GROUPS = 3;
	localparam int CW_GROUP_W = 32;
	localparam int ADDR_W = 24;
	localparam int PAGE_BIT = 23;
	localparam int SYND_W = 24;

	localparam int SYN_IPAR = 0;
	localparam int SYN_DPAR = 1;
	localparam int SYN_IRED = 2;
	localparam int SYN_DRED = 3;
	localparam int SYN_TMO = 4;
	localparam int SYN_IUAR = 5;
	localparam int SYN_CS0 = 6;
	localparam int SYN_CS1 = 7;
	localparam int SYN_CS2 = 8;
	localparam int SYN_PGX = 9;

	typedef enum logic [1:0] {
		AEC_IDLE = 2'b00,
		AEC_STALL = 2'b01,
		AEC_FETCH = 2'b10
	} aec_derail_e;

	typedef struct packed {
		logic [1:0] par;
		logic red;
		logic unavail;
	} aec_ibuf_s;

	typedef struct packed {
		logic [1:0] par;
		logic red;
	} aec_dbuf_s;

	typedef struct packed {
		aec_ibuf_s [7:0] ibuf;
		aec_dbuf_s [1:0] dbuf;
		logic strobe_even_d;
		logic strobe_odd_d;
		logic addr_bit_d;
		logic page_cross_flag;
		logic ipar_latched;
		logic ired_latched;
		logic iuar_latched;
		logic collect_d;
		logic syndrome_clock;
		logic [SYND_W-1:0] syndrome_bits;
		logic [TIMER_W-1:0] uar_timer;
		logic uar_busy;
		logic uar_master;
		logic unavailable_timeout;
		aec_derail_e derail;
		logic [7:0] derail_count;
		logic derail_flop;
	} aec_state_s;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [15:0] out_data;
		logic [15:0] chnl_data;
		logic mem_write;
		logic cmd;
	} aec_bus_req_s;

	typedef struct packed {
		logic [2:0] addr_parity;
		logic [1:0] data_parity;
		logic cmd_parity;
	} aec_bus_par_s;

endpackage

/* File: testbench/aec_mem_model.sv */
/* Memory-side model: hands over halfwords with odd byte parity and a red flag.
   Assumes single-cycle deliver requests from the bench; answers the next cycle. */
`timescale 1ns/10ps
module aec_mem_model (
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	input wire logic deliver_in,
	input wire logic to_instr_in,
	input wire logic [15:0] word_in,
	input wire logic bad_in,
	input wire logic red_in,
	output logic strobe_even_out,
	output logic strobe_odd_out,
	output logic [1:0] parity_out,
	output logic red_out
);
	logic [1:0] phase;
	logic [1:0] par_q;
	logic red_q;
	logic live;
	// Lines no longer held show the inverse of their last value.
	assign parity_out = live ? par_q : ~par_q;
	assign red_out = live ? red_q : ~red_q;
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			phase <= 2'h0;
			strobe_even_out <= 1'b0;
			strobe_odd_out <= 1'b0;
			par_q <= 2'h0;
			red_q <= 1'b0;
			live <= 1'b0;
		end else begin
			live <= deliver_in;
			if (deliver_in) begin
				par_q <= {~^word_in[15:8], ~^word_in[7:0]} ^ {2{bad_in}};
				red_q <= red_in;
				if (to_instr_in) begin
					phase <= phase + 2'h1;
					if (phase[0])
						strobe_even_out <= ~phase[1];
					else
						strobe_odd_out <= ~phase[1];
				end
			end
		end
	end
endmodule

/* File: testbench/availability_error_checking_tb_top.sv */
/* Bench: parity generation table, then error, syndrome, derail and timeout cases.
   Assumes the memory model answers a delivery one cycle after the request. */
`timescale 1ns/10ps
module availability_error_checking_tb_top;
	localparam int UARC = 8;
	localparam int UARM = 12;
	localparam int DRC = 10;
	localparam logic [95:0] CWOK = 96'h800000008000000080000000;
	typedef struct packed {
		aec_pkg::aec_bus_req_s req;
		logic [3:0] ctl;
		logic [5:0] exp;
	} aec_row_s;
	logic clk = 1'b0, rst_n = 1'b0, step = 1'b0, rs = 1'b0, rrd = 1'b0, rdn = 1'b0, cz = 1'b0;
	logic rem = 1'b0, bst = 1'b0, cen = 1'b0, onl = 1'b1, frc = 1'b0, etd = 1'b0, ld = 1'b0;
	logic tc = 1'b1, tl = 1'b0, isamp = 1'b0, blk = 1'b0, inh = 1'b0, dlv = 1'b0, ti = 1'b0;
	logic bad = 1'b0, red = 1'b0, se, so, mred, gec, syc, dpe, tmo, pgx, drl, stl, nac, ebk;
	logic mid = 1'b1, lld = 1'b0, lpm = 1'b0;
	logic [1:0] tp = 2'h0, iload = 2'h0, drv = 2'h0, mpar;
	logic [7:0] ib = 8'h00;
	logic [15:0] rbus = 16'h0000, word = 16'h0000;
	logic [23:0] iaddr = 24'h000000, syn;
	logic [95:0] cw = CWOK;
	aec_pkg::aec_bus_req_s req = '0;
	aec_pkg::aec_bus_par_s bpar;
	int error_cnt = 0, check_count = 0, n, c, d, s;
	aec_row_s rows [7] = '{
		'{'{24'h000000, 16'h0000, 16'hFFFF, 1'b1, 1'b0}, 4'hE, 6'h3F},
		'{'{24'h000001, 16'h0001, 16'h0000, 1'b1, 1'b1}, 4'hE, 6'h34},
		'{'{24'h010000, 16'h0001, 16'h0100, 1'b0, 1'b0}, 4'hB, 6'h1A},
		'{'{24'h000000, 16'h0000, 16'h0000, 1'b1, 1'b0}, 4'h9, 6'h18},
		'{'{24'h000000, 16'h0000, 16'h0000, 1'b1, 1'b1}, 4'hF, 6'h3E},
		'{'{24'h000000, 16'h0000, 16'h0000, 1'b0, 1'b0}, 4'hD, 6'h1F},
		'{'{24'hFFFFFF, 16'hFFFF, 16'hFFFF, 1'b1, 1'b1}, 4'h6, 6'h00}};

	aec_mem_model mem (.sys_clk_in(clk), .rst_n_in(rst_n), .deliver_in(dlv), .to_instr_in(ti),
		.word_in(word), .bad_in(bad), .red_in(red), .strobe_even_out(se),
		.strobe_odd_out(so), .parity_out(mpar), .red_out(mred));

	aec_availability #(.UAR_COUNT(UARC), .UAR_MASTER_COUNT(UARM), .DERAIL_COUNT(DRC)) dut (
		.sys_clk_in(clk), .rst_n_in(rst_n), .prefetch_strobe_even_in(se),
		.prefetch_strobe_odd_in(so), .mem_parity_in(mpar), .uncorrectable_indicator_in(mred),
		.take_pair_in(tp), .take_low_in(tl), .instr_byte_in(ib), .instr_sample_in(isamp),
		.instr_error_block_in(blk), .error_inhibit_in(inh), .inr_load_in(iload),
		.inr_drive_in(drv), .result_bus_in(rbus), .mid_cycle_in(mid), .step_start_in(step),
		.ref_start_in(rs), .ref_read_in(rrd), .ref_done_in(rdn), .channel_zero_in(cz),
		.instr_addr_in(iaddr), .instr_addr_low_load_in(lld), .instr_remove_in(rem),
		.long_procedure_mode_in(lpm), .control_word_in(cw), .bus_req_in(req),
		.bus_start_in(bst), .command_parity_enable_in(cen), .online_flag_in(onl),
		.force_error_flag_in(frc), .error_trap_disable_in(etd), .load_syndrome_cmd_in(ld),
		.test_condition_in(tc), .bus_par_out(bpar), .general_error_collector_out(gec),
		.syndrome_clock_out(syc), .syndrome_bits_out(syn), .data_parity_error_out(dpe),
		.unavailable_timeout_out(tmo), .page_cross_flag_out(pgx), .derail_flop_out(drl),
		.clock_stall_out(stl), .next_addr_clear_out(nac), .else_bank_enable_out(ebk));

	initial begin
		forever #2.5 clk = ~clk;
	end

	task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
		check_count++;
		if (e !== g) begin
			$display("FAIL %s expected %h seen %h", nm, e, g);
			error_cnt++;
		end
	endtask

	task automatic conclude();
		$display("errors %0d checks %0d", error_cnt, check_count);
		if (error_cnt == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic give(input logic [15:0] w, input logic b, r, t, input logic [1:0] l);
		@(posedge clk);
		{dlv, word, bad, red, ti} <= {1'b1, w, b, r, t};
		@(posedge clk);
		dlv <= 1'b0;
		iload <= l;
		@(posedge clk);
		iload <= 2'h0;
		drv <= l;
		rbus <= w;
	endtask

	// Fires a step, checks the captured syndrome, then measures the derail.
	task automatic fire(input logic [23:0] e, input logic dr);
		@(posedge clk);
		step <= 1'b1;
		@(posedge clk);
		step <= 1'b0;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (syc !== 1'b1 && n < 4);
		chk("syndrome", e, syn);
		@(posedge clk);
		{cw, ld, etd, isamp, rem, drv} <= {CWOK, 6'h00};
		{c, d, s} = 0;
		repeat (20) begin
			@(negedge clk);
			{c, d, s} = {c + nac, d + drl, s + stl};
			if (drl)
				chk("else_bank", 1, ebk);
		end
		chk("derail", dr * (DRC + 1), d);
		chk("stall", d, s);
		chk("addr_clear", dr * DRC, c);
		chk("syndrome_hold", e, syn);
	endtask

	task automatic wait_tmo(input logic z, input logic r, input int e);
		@(posedge clk);
		{cz, rrd, rs} <= {z, r, 1'b1};
		@(posedge clk);
		rs <= 1'b0;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (tmo !== 1'b1 && n < 40);
		chk("timeout", e + 1, n);
		chk("tmo_collector", 1, gec);
	endtask

	initial begin
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		@(negedge clk);
		chk("reset", 0, {gec, syc, syn, dpe, tmo, pgx, drl, stl, nac, ebk, bpar});
		foreach (rows[i]) begin
			@(posedge clk);
			req <= rows[i].req;
			{bst, cen, onl, frc} <= rows[i].ctl;
			@(negedge clk);
			chk("bus_par", rows[i].exp, bpar);
		end
		@(posedge clk);
		tc <= 1'b0;
		@(negedge clk);
		chk("else_bank_cond", 1, ebk);
		@(posedge clk);
		{tc, ld} <= 2'h3;
		@(negedge clk);
		chk("ld_collector", 1, gec);
		fire(24'h000000, 1'b1);
		for (int g = 0; g < 3; g++) begin
			@(posedge clk);
			cw <= CWOK ^ (96'h1 << (32 * g));
			@(negedge clk);
			chk("cw_collector", 1, gec);
			fire(24'h000001 << (aec_pkg::SYN_CS0 + g), 1'b1);
		end
		@(posedge clk);
		{etd, cw} <= {1'b1, CWOK ^ 96'h2};
		fire(24'h000001 << aec_pkg::SYN_CS0, 1'b0);
		give(16'h0000, 1'b1, 1'b0, 1'b0, 2'h1);
		@(negedge clk);
		chk("dpe", 1, dpe);
		@(posedge clk);
		inh <= 1'b1;
		@(negedge clk);
		chk("dpe_inhibit", 0, dpe);
		@(posedge clk);
		inh <= 1'b0;
		fire(24'h000001 << aec_pkg::SYN_DPAR, 1'b1);
		give(16'h1234, 1'b0, 1'b1, 1'b0, 2'h2);
		@(negedge clk);
		chk("dpe_reg1", 0, dpe);
		fire(24'h000001 << aec_pkg::SYN_DRED, 1'b1);
		give(16'h2727, 1'b1, 1'b1, 1'b1, 2'h0);
		{ib, isamp, mid} <= {8'h27, 2'h2};
		repeat (2) @(negedge clk);
		chk("ipar_no_mid", 0, gec);
		@(posedge clk);
		{blk, inh, mid} <= 3'h7;
		repeat (2) @(negedge clk);
		chk("ipar_blocked", 0, gec);
		@(posedge clk);
		{blk, inh} <= 2'h0;
		repeat (2) @(negedge clk);
		chk("ipar_collector", 1, gec);
		fire(24'h000005, 1'b1);
		@(posedge clk);
		{iaddr, lld} <= {24'h800000, 1'b1};
		@(posedge clk);
		iaddr <= 24'h000000;
		repeat (2) @(negedge clk);
		chk("page_cross_load", 0, pgx);
		@(posedge clk);
		{iaddr, lld} <= {24'h800000, 1'b0};
		@(posedge clk);
		iaddr <= 24'h000000;
		repeat (2) @(negedge clk);
		chk("page_cross", 1, pgx);
		give(16'h2626, 1'b0, 1'b0, 1'b1, 2'h0);
		{tp, rem, lpm} <= {2'h1, 2'h3};
		repeat (2) @(negedge clk);
		chk("uar_long_mode", 0, gec);
		@(posedge clk);
		lpm <= 1'b0;
		repeat (2) @(negedge clk);
		chk("uar_collector", 1, gec);
		fire(24'h000001 << aec_pkg::SYN_IUAR, 1'b1);
		wait_tmo(1'b0, 1'b0, UARC);
		wait_tmo(1'b1, 1'b1, UARM);
		@(posedge clk);
		rs <= 1'b1;
		@(posedge clk);
		{rs, rdn} <= 2'h1;
		@(posedge clk);
		rdn <= 1'b0;
		n = 0;
		repeat (30) @(negedge clk) n += tmo;
		chk("tmo_cancel", 0, n);
		conclude();
	end

	initial begin
		repeat (5000) @(posedge clk);
		error_cnt++;
		conclude();
	end
endmodule
